// ### vdar_pkg.sv
// Constants, register map and state types of the voltage-dip restart supervisor.
// Assumes one 25 MHz system clock and the plain register port of vdar_supervisor.
package vdar_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned TICK_NS = 100_000_000;               // 0.1 s base step
    localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam logic [7:0] TENTHS_PER_S = 8'h0A;
    localparam logic [7:0] REPEAT_WIN = 8'h0A;                    // 1 s
    localparam logic [7:0] OCCUR_WIN = 8'h2D;                     // 4.5 s
    localparam logic [6:0] PCT_SCALE = 7'h64;                     // 100 %

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_NOMV = 8'h04;
    localparam logic [7:0] A_THR = 8'h08;
    localparam logic [7:0] A_IMMTO = 8'h0C;
    localparam logic [7:0] A_DELTO = 8'h10;
    localparam logic [7:0] A_DRTO = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_EVT = 8'h1C;
    localparam logic [7:0] A_MASK = 8'h20;
    localparam logic [7:0] A_CNTIMM = 8'h24;
    localparam logic [7:0] A_CNTDEL = 8'h28;
    localparam logic [7:0] A_CNTMAN = 8'h2C;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h2;
    localparam logic [15:0] NOMV_RST = 16'h0190;
    localparam logic [7:0] DIPPCT_RST = 8'h41;                    // 65 %
    localparam logic [7:0] RSTPCT_RST = 8'h5A;                    // 90 %
    localparam logic [7:0] IMMTO_RST = 8'h02;                     // 0.2 s in tenths
    localparam logic [8:0] DELTO_RST = 9'h004;                    // 4 s
    localparam logic [8:0] DELTO_INF = 9'h12D;                    // 301 s = infinite
    localparam logic [13:0] DRTO_RST = 14'h0002;                  // 2 s
    localparam int unsigned EVT_W = 4;
    localparam int unsigned EV_DIP = 0;
    localparam int unsigned EV_IMM = 1;
    localparam int unsigned EV_DEL = 2;
    localparam int unsigned EV_MAN = 3;

    // Gray along run -> dip -> delayed -> manual
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DIP = 2'b01,
        ST_DELAY = 2'b11,
        ST_MANUAL = 2'b10
    } vdar_state_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [15:0] nomV;
        logic [7:0] dipPct;
        logic [7:0] rstPct;
        logic [7:0] immTo;
        logic [8:0] delTo;
        logic [13:0] drTo;
        logic [EVT_W-1:0] mask;
    } vdar_cfg_t;

    typedef struct packed {
        logic dipDetected;
        logic dipOccurred;
        logic condImm;
        logic condDel;
        logic condMan;
        logic motorOut;
    } vdar_flags_t;

    typedef struct packed {
        vdar_cfg_t cfg;
        vdar_flags_t flg;
        vdar_state_t st;
        logic [21:0] tickCnt;
        logic [11:0] durCnt;
        logic [11:0] delLeft;
        logic delInf;
        logic [7:0] immSnap;
        logic [16:0] holdCnt;
        logic [16:0] holdSnap;
        logic [7:0] sinceDip;
        logic prevDip;
        logic repeatDip;
        logic [EVT_W-1:0] evt;
        logic [15:0] cntImm;
        logic [15:0] cntDel;
        logic [15:0] cntMan;
        logic [31:0] rdData;
        logic irq;
    } vdar_regs_t;

endpackage

// ### vdar_supervisor.sv
// Voltage-dip automatic restart supervisor: dip detection, duration
// classification, delayed-restart timing, status, counters and registers.
// Assumes synchronous inputs on clk_sys and a single-cycle strobe register port.
//
// Overview of operation
// - Dip restart handling acts only when the dip mode setting is 2.
// - Dips are found from instantaneous phase voltage against shared thresholds.
// - Three outcomes: immediate restart, delayed restart, manual restart.
// - Manual outcome keeps the motor stopped until a run command.
// - Dip duration runs from voltage loss until voltage restoration.
// - Dip releases the output; auto outcome drives it again.
// - A short dip that repeats within 1 s gets the delayed or manual outcome, as a long dip does.
// - Immediate timeout is set in tenths of a second, default 0.2 s.
// - Delayed timeout 0 to 300 s, default 4 s; 301 means infinite.
// - Dip restart timeout in whole seconds, default 2 s.
// - Dip threshold 65 % and restart threshold 90 % of nominal voltage.
// - Dip detection flag is high for the whole dip.
// - Dip occurred flag is high within 4.5 s of the last dip.
// - One condition flag and one counter for each outcome.
// - Delayed timer pauses while a new dip lasts.
// - Start or stop command cancels a pending delayed restart.
// - A running timer keeps its old duration after a setting change.
module vdar_supervisor #(
    parameter int unsigned TICK_CYCLES = vdar_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Measurement and commands
    input wire logic [15:0] phaseVolt,
    input wire logic runCmd,
    input wire logic stopCmd,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // Motor drive, status and interrupt
    output logic motorOut,
    output logic dipDetected,
    output logic dipOccurred,
    output logic condImm,
    output logic condDel,
    output logic condMan,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int unsigned EVT_W_L = vdar_pkg::EVT_W;
    localparam logic [21:0] TICK_LAST = 22'(TICK_CYCLES - 1);

    vdar_pkg::vdar_regs_t r;
    vdar_pkg::vdar_regs_t next_r;

    logic [23:0] voltScaled;
    logic [23:0] dipLevel;
    logic [23:0] rstLevel;
    logic belowDip;
    logic aboveRst;
    logic tick;
    logic autoOn;
    logic [EVT_W_L-1:0] evtSet;
    logic [EVT_W_L-1:0] evtClr;

    // Threshold compare in percent of nominal; multiply avoids a divider
    assign voltScaled = 24'(phaseVolt) * 24'(vdar_pkg::PCT_SCALE);
    assign dipLevel = 24'(r.cfg.nomV) * 24'(r.cfg.dipPct);
    assign rstLevel = 24'(r.cfg.nomV) * 24'(r.cfg.rstPct);
    assign belowDip = voltScaled < dipLevel;
    assign aboveRst = voltScaled >= rstLevel;
    assign tick = r.tickCnt == TICK_LAST;
    assign autoOn = r.cfg.mode == vdar_pkg::MODE_AUTO;

    // Registered outputs
    assign regRdData = r.rdData;
    assign motorOut = r.flg.motorOut;
    assign dipDetected = r.flg.dipDetected;
    assign dipOccurred = r.flg.dipOccurred;
    assign condImm = r.flg.condImm;
    assign condDel = r.flg.condDel;
    assign condMan = r.flg.condMan;
    assign irq = r.irq;

    // ------------------------------------------------------------
    // Behaviour notes
    // ------------------------------------------------------------
    // Timebase
    //   Free-running tick every TICK_CYCLES clocks, a tenth of a second.
    //   Durations count whole ticks, so each is good to one tick.
    // Dip detection
    //   Voltage times 100 against nominal times percent: no divider.
    //   Two thresholds give hysteresis between dip and restore.
    //   Only a driven motor in the run state starts a sequence.
    //   A stopped motor has nothing to restart, so its dips pass.
    // Classification
    //   Duration runs from dip entry until the restore compare holds.
    //   Short and isolated: drive again on the cycle after restore.
    //   Short but repeated: falls to the delayed or manual outcome.
    //   Delayed timer still running at restore: delayed restart.
    //   Delayed timer already expired: wait for the operator.
    //   Infinite delayed setting never expires, never goes manual.
    // Delayed restart
    //   Timer loaded at dip entry, so the dip uses up delay time.
    //   A new dip freezes the timer and clears the hold count.
    //   Restore must hold for the dip restart time before drive.
    //   Run or stop cancels; run also drives the motor at once.
    // Manual restart
    //   Drive stays off whatever the voltage does, until a run.
    //   Stop beside run keeps the drive off.
    // Settings
    //   Timer settings are copied at dip entry.
    //   A write during a sequence acts from the next dip on.
    //   Thresholds are read live, so their writes act at once.
    //   Leaving the auto mode aborts a sequence, drive off.
    // Status and counters
    //   Condition flags are levels; immediate lasts to next dip.
    //   A counter steps when its sequence is entered.
    //   A cancelled delayed sequence still counts as entered.
    //   Counters wrap at 16 bits; software must read them often.
    //   Recent-dip flag spans the live dip and 4.5 s from its start.
    // Events and interrupt
    //   Event bits are sticky and clear on a read of their register.
    //   An event in the read cycle survives the clear: none lost.
    //   Interrupt level is registered together with the events.
    // Register port
    //   Read data stands for one cycle only, zero otherwise.
    //   Writes to read-only or unmapped offsets are dropped.
    //   No wait states: a write completes in its own cycle, read data follows in the next.

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        evtSet = '0;
        evtClr = '0;
        next_r.rdData = '0;

        // 0.1 s base tick, all timers step on it
        next_r.tickCnt = tick ? '0 : r.tickCnt + 22'h00_0001;

        // Time since last dip start, saturating
        if (tick && r.sinceDip != 8'hFF)
        begin
            next_r.sinceDip = r.sinceDip + 8'h01;
        end

        // Operator commands act directly outside a dip
        if (runCmd && r.st != vdar_pkg::ST_DIP)
        begin
            next_r.flg.motorOut = 1'b1;
        end
        if (stopCmd)
        begin
            next_r.flg.motorOut = 1'b0;
        end

        case (r.st)
            vdar_pkg::ST_RUN:
            begin
                // Only a running motor under auto mode enters a sequence
                if (autoOn && belowDip && r.flg.motorOut)
                begin
                    next_r.st = vdar_pkg::ST_DIP;
                    next_r.flg.motorOut = 1'b0;
                    next_r.flg.dipDetected = 1'b1;
                    next_r.flg.condImm = 1'b0;
                    next_r.durCnt = '0;
                    // Snapshot settings so later writes wait for the next dip
                    next_r.immSnap = r.cfg.immTo;
                    next_r.delInf = r.cfg.delTo == vdar_pkg::DELTO_INF;
                    // Widen before the product so 300 s and 9999 s do not wrap
                    next_r.delLeft = 12'(r.cfg.delTo) * 12'(vdar_pkg::TENTHS_PER_S);
                    next_r.holdSnap = 17'(r.cfg.drTo) * 17'(vdar_pkg::TENTHS_PER_S);
                    next_r.repeatDip = r.prevDip
                        && r.sinceDip < vdar_pkg::REPEAT_WIN;
                    next_r.sinceDip = '0;
                    next_r.prevDip = 1'b1;
                    evtSet[vdar_pkg::EV_DIP] = 1'b1;
                end
            end

            vdar_pkg::ST_DIP:
            begin
                next_r.flg.motorOut = 1'b0;
                if (tick)
                begin
                    if (r.durCnt != 12'hFFF)
                    begin
                        next_r.durCnt = r.durCnt + 12'h001;
                    end
                    if (r.delLeft != '0)
                    begin
                        next_r.delLeft = r.delLeft - 12'h001;
                    end
                end
                if (aboveRst)
                begin
                    next_r.flg.dipDetected = 1'b0;
                    next_r.holdCnt = '0;
                    if (r.durCnt < 12'(r.immSnap) && !r.repeatDip)
                    begin
                        next_r.st = vdar_pkg::ST_RUN;
                        next_r.flg.motorOut = 1'b1;
                        next_r.flg.condImm = 1'b1;
                        next_r.cntImm = r.cntImm + 16'h0001;
                        evtSet[vdar_pkg::EV_IMM] = 1'b1;
                    end
                    else if (r.delInf || r.delLeft != '0)
                    begin
                        next_r.st = vdar_pkg::ST_DELAY;
                        next_r.flg.condDel = 1'b1;
                        next_r.cntDel = r.cntDel + 16'h0001;
                        evtSet[vdar_pkg::EV_DEL] = 1'b1;
                    end
                    else
                    begin
                        next_r.st = vdar_pkg::ST_MANUAL;
                        next_r.flg.condMan = 1'b1;
                        next_r.cntMan = r.cntMan + 16'h0001;
                        evtSet[vdar_pkg::EV_MAN] = 1'b1;
                    end
                end
            end

            vdar_pkg::ST_DELAY:
            begin
                next_r.flg.motorOut = 1'b0;
                next_r.flg.dipDetected = belowDip
                    || (r.flg.dipDetected && !aboveRst);
                if (belowDip && !r.flg.dipDetected)
                begin
                    next_r.sinceDip = '0;
                    evtSet[vdar_pkg::EV_DIP] = 1'b1;
                end
                // Timer frozen while a new dip lasts
                if (tick && !next_r.flg.dipDetected && r.delLeft != '0)
                begin
                    next_r.delLeft = r.delLeft - 12'h001;
                end
                // Restored voltage must hold for the dip restart timeout
                if (next_r.flg.dipDetected)
                begin
                    next_r.holdCnt = '0;
                end
                else if (tick && r.holdCnt != 17'h1_FFFF)
                begin
                    next_r.holdCnt = r.holdCnt + 17'h0_0001;
                end
                if (runCmd || stopCmd)
                begin
                    next_r.st = vdar_pkg::ST_RUN;
                    next_r.flg.condDel = 1'b0;
                    next_r.flg.dipDetected = 1'b0;
                    next_r.flg.motorOut = runCmd && !stopCmd;
                end
                else if (!r.delInf && r.delLeft == '0 && !next_r.flg.dipDetected
                    && r.holdCnt >= r.holdSnap)
                begin
                    next_r.st = vdar_pkg::ST_RUN;
                    next_r.flg.condDel = 1'b0;
                    next_r.flg.motorOut = 1'b1;
                end
            end

            vdar_pkg::ST_MANUAL:
            begin
                // No self restart: only a run command or leaving auto mode leaves
                next_r.flg.motorOut = 1'b0;
                if (runCmd && !stopCmd)
                begin
                    next_r.st = vdar_pkg::ST_RUN;
                    next_r.flg.condMan = 1'b0;
                    next_r.flg.motorOut = 1'b1;
                end
            end

            default:
            begin
                next_r.st = vdar_pkg::ST_RUN;
            end
        endcase

        // Leaving auto mode drops any sequence
        if (!autoOn && r.st != vdar_pkg::ST_RUN)
        begin
            next_r.st = vdar_pkg::ST_RUN;
            next_r.flg.dipDetected = 1'b0;
            next_r.flg.condDel = 1'b0;
            next_r.flg.condMan = 1'b0;
        end

        // Recent-dip flag covers the live dip and 4.5 s after its start
        next_r.flg.dipOccurred = next_r.flg.dipDetected
            || (next_r.prevDip && next_r.sinceDip < vdar_pkg::OCCUR_WIN);

        // Register writes; settings feed timers only at their next start
        if (regWr)
        begin
            case (regAddr)
                vdar_pkg::A_CTRL: next_r.cfg.mode = regWrData[1:0];
                vdar_pkg::A_NOMV: next_r.cfg.nomV = regWrData[15:0];
                vdar_pkg::A_THR:
                begin
                    next_r.cfg.dipPct = regWrData[7:0];
                    next_r.cfg.rstPct = regWrData[15:8];
                end
                vdar_pkg::A_IMMTO: next_r.cfg.immTo = regWrData[7:0];
                vdar_pkg::A_DELTO: next_r.cfg.delTo = regWrData[8:0];
                vdar_pkg::A_DRTO: next_r.cfg.drTo = regWrData[13:0];
                vdar_pkg::A_MASK: next_r.cfg.mask = regWrData[EVT_W_L-1:0];
                default: next_r.cfg = r.cfg;
            endcase
        end

        // Register reads, data valid in the following cycle
        if (regRd)
        begin
            case (regAddr)
                vdar_pkg::A_CTRL: next_r.rdData = 32'(r.cfg.mode);
                vdar_pkg::A_NOMV: next_r.rdData = 32'(r.cfg.nomV);
                vdar_pkg::A_THR: next_r.rdData = 32'({r.cfg.rstPct, r.cfg.dipPct});
                vdar_pkg::A_IMMTO: next_r.rdData = 32'(r.cfg.immTo);
                vdar_pkg::A_DELTO: next_r.rdData = 32'(r.cfg.delTo);
                vdar_pkg::A_DRTO: next_r.rdData = 32'(r.cfg.drTo);
                vdar_pkg::A_STAT: next_r.rdData = 32'({r.st, r.flg});
                vdar_pkg::A_EVT:
                begin
                    next_r.rdData = 32'(r.evt);
                    evtClr = r.evt;
                end
                vdar_pkg::A_MASK: next_r.rdData = 32'(r.cfg.mask);
                vdar_pkg::A_CNTIMM: next_r.rdData = 32'(r.cntImm);
                vdar_pkg::A_CNTDEL: next_r.rdData = 32'(r.cntDel);
                vdar_pkg::A_CNTMAN: next_r.rdData = 32'(r.cntMan);
                default: next_r.rdData = '0;
            endcase
        end

        // Sticky events: a new event beats a read clear in the same cycle
        next_r.evt = (r.evt & ~evtClr) | evtSet;
        next_r.irq = |(next_r.evt & next_r.cfg.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
            r.cfg.mode <= vdar_pkg::MODE_NONE;
            r.cfg.nomV <= vdar_pkg::NOMV_RST;
            r.cfg.dipPct <= vdar_pkg::DIPPCT_RST;
            r.cfg.rstPct <= vdar_pkg::RSTPCT_RST;
            r.cfg.immTo <= vdar_pkg::IMMTO_RST;
            r.cfg.delTo <= vdar_pkg::DELTO_RST;
            r.cfg.drTo <= vdar_pkg::DRTO_RST;
            r.st <= vdar_pkg::ST_RUN;
            r.sinceDip <= 8'hFF;
        end
        else
        begin
            r <= next_r;
        end
    end

endmodule

// ### vdar_line_model.sv
// Far-side model: phase voltage source feeding the supervisor.
// Assumes nominal voltage register left at its reset value of 400.
module vdar_line_model (
    // Control from the bench
    input wire logic lowReq,
    // Measured phase voltage
    output logic [15:0] phaseVolt
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Voltage levels
    // ------------------------------------------------------------
    // Deep dip well under 65 %, healthy level at 100 % so restore is clear
    assign phaseVolt = lowReq ? 16'h0064 : 16'h0190;
endmodule

// ### vdar_supervisor_checker.sv
// Concurrent checks on the ports of the dip restart supervisor.
// Assumes one clock domain and the active-low asynchronous reset.
module vdar_supervisor_checker #(
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Inputs
    input wire logic [15:0] phaseVolt,
    input wire logic runCmd,
    input wire logic stopCmd,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    // Outputs
    input wire logic [31:0] regRdData,
    input wire logic motorOut,
    input wire logic dipDetected,
    input wire logic dipOccurred,
    input wire logic condImm,
    input wire logic condDel,
    input wire logic condMan,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    AST_DIP_NO_RUN: assert property (dipDetected |-> !motorOut)
        else $error("motor driven during dip");
    AST_OCC_HOLD: assert property ($rose(dipDetected) |-> dipOccurred [*8])
        else $error("dip occurred flag not held");
    AST_DIP_OCC: assert property (dipDetected |-> dipOccurred)
        else $error("dip flag without occurred flag");
    AST_MAN_STOPPED: assert property (condMan |-> !motorOut)
        else $error("motor runs while manual restart waits");
    AST_ONE_COND: assert property ($onehot0({condImm, condDel, condMan}))
        else $error("more than one restart condition");
    AST_STOP_CANCEL: assert property (condDel && stopCmd |=> !condDel && !motorOut)
        else $error("stop did not cancel delayed restart");
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000)
        else $error("read data outside read cycle");
    AST_IMM_RESTART: assert property ($rose(condImm) |-> motorOut && !dipDetected)
        else $error("immediate condition without restart");
    AST_DEL_STOPPED: assert property (condDel |-> !motorOut)
        else $error("motor runs while delayed restart pending");
endmodule

// ### testbench.sv
// Self-checking bench for the dip restart supervisor.
// Assumes a shortened tick so one second is 100 clock cycles.
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TK = 10;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic lowReq = 1'b0;
    logic runCmd = 1'b0;
    logic stopCmd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] phaseVolt;
    logic [31:0] regRdData;
    logic motorOut, dipDetected, dipOccurred, condImm, condDel, condMan, irq;
    int err_total = 0;
    int cmp_count = 0;

    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    always #20 clk_sys = ~clk_sys;

    vdar_line_model line (.lowReq(lowReq), .phaseVolt(phaseVolt));

    vdar_supervisor #(.TICK_CYCLES(TK)) uut (.clk_sys(clk_sys), .nrst(nrst),
        .phaseVolt(phaseVolt), .runCmd(runCmd), .stopCmd(stopCmd), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .motorOut(motorOut), .dipDetected(dipDetected), .dipOccurred(dipOccurred),
        .condImm(condImm), .condDel(condDel), .condMan(condMan), .irq(irq));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        `CHK(nm, e, regRdData)
    endtask

    task automatic pulse(input logic stop);
        @(posedge clk_sys);
        if (stop)
            stopCmd <= 1'b1;
        else
            runCmd <= 1'b1;
        @(posedge clk_sys);
        stopCmd <= 1'b0;
        runCmd <= 1'b0;
    endtask

    // Mid-dip look at the drive, so a late release is caught
    task automatic dip(input int n, input logic stopped);
        @(posedge clk_sys);
        lowReq <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("motorOut", !stopped, motorOut)
        `CHK("dipDetected", stopped, dipDetected)
        repeat (n - 3) @(posedge clk_sys);
        lowReq <= 1'b0;
    endtask

    // Bounded wait on motor (0), delayed (1) or manual (2) flag
    task automatic wait_for(input int sel, input logic v, input int lim);
        logic s;
        for (int n = 0; n < lim; n++)
        begin
            @(posedge clk_sys);
            #1;
            s = (sel == 0) ? motorOut : (sel == 1) ? condDel : condMan;
            if (s === v)
                return;
        end
        err_total++;
        $display("[ERR] wait%0d exp %0b got timeout", sel, v);
        end_of_test();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(vdar_pkg::A_THR, 32'h0000_5A41, "thr");
        rd(vdar_pkg::A_IMMTO, 32'h0000_0002, "immTo");
        rd(vdar_pkg::A_DELTO, 32'h0000_0004, "delTo");
        rd(vdar_pkg::A_DRTO, 32'h0000_0002, "drTo");
        rd(vdar_pkg::A_CTRL, 32'h0000_0000, "mode");
        rd(8'h30, 32'h0000_0000, "unmapped");
        pulse(1'b0);
        wait_for(0, 1'b1, 20);
        // Dip ignored while restart handling is off
        dip(30, 1'b0);
        wr(vdar_pkg::A_CTRL, 32'h0000_0002);
        wr(vdar_pkg::A_MASK, 32'h0000_000F);
        repeat (120) @(posedge clk_sys);
        dip(5, 1'b1);
        wait_for(0, 1'b1, 20);
        `CHK("condImm", 1'b1, condImm)
        `CHK("irq", 1'b1, irq)
        rd(vdar_pkg::A_CNTIMM, 32'h0000_0001, "cntImm");
        rd(vdar_pkg::A_EVT, 32'h0000_0003, "evt");
        @(posedge clk_sys);
        #1;
        `CHK("irqClr", 1'b0, irq)
        // Repeat within one second, then cancelled by stop
        dip(5, 1'b1);
        wait_for(1, 1'b1, 20);
        pulse(1'b1);
        #1;
        `CHK("condDel", 1'b0, condDel)
        repeat (800) @(posedge clk_sys);
        `CHK("motorOut", 1'b0, motorOut)
        rd(vdar_pkg::A_CNTDEL, 32'h0000_0001, "cntDel0");
        pulse(1'b0);
        wait_for(0, 1'b1, 20);
        // Delayed restart keeps old timeout after a mid-run change
        repeat (120) @(posedge clk_sys);
        dip(5, 1'b1);
        wait_for(0, 1'b1, 20);
        dip(30, 1'b1);
        wr(vdar_pkg::A_DELTO, 32'h0000_0010);
        `CHK("condDel", 1'b1, condDel)
        wait_for(0, 1'b1, 900);
        rd(vdar_pkg::A_CNTDEL, 32'h0000_0002, "cntDel");
        // Long dip needs a run command
        wr(vdar_pkg::A_DELTO, 32'h0000_0004);
        repeat (120) @(posedge clk_sys);
        dip(500, 1'b1);
        wait_for(2, 1'b1, 20);
        repeat (50) @(posedge clk_sys);
        `CHK("motorOut", 1'b0, motorOut)
        `CHK("dipOccurred", 1'b0, dipOccurred)
        pulse(1'b0);
        wait_for(0, 1'b1, 20);
        rd(vdar_pkg::A_CNTMAN, 32'h0000_0001, "cntMan");
        end_of_test();
    end
endmodule

bind vdar_supervisor vdar_supervisor_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
    .clk_sys(clk_sys), .nrst(nrst), .phaseVolt(phaseVolt), .runCmd(runCmd),
    .stopCmd(stopCmd), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .motorOut(motorOut),
    .dipDetected(dipDetected), .dipOccurred(dipOccurred), .condImm(condImm),
    .condDel(condDel), .condMan(condMan), .irq(irq));
